/* rtl/acc_cal_control.sv */
// Calibration control: registers, calibration sequencer, divider resets
//
// Behaviour
// - Run bit 1 runs calibration, 0 holds it in reset; it resets to 1.
// - A cleared run bit also resets the core and serial link dividers.
// - Mode bit 3 enables background offset cal, only with background on.
// - Mode bit 2 enables foreground offset cal, only with foreground on.
// - Mode bit 1 enables background calibration and resets to 0.
// - Every start clears values, then mode bit 0 (reset 1) runs or skips foreground.
// - Reference bit 2 at 0 aims offset calibration at mid-code.
// - Reference bit 2 at 1, with mode bit 1 (background) on, matches each converter's offset to its spare.
// - Averaging bits 6:4, reset 6, set the offset routine depth.
// - Averaging bits 2:0, reset 1, set the linearity routine depth.
// - A done flag rises once foreground calibration ends or is skipped.
`timescale 1ns/1ps
module acc_cal_control
  import acc_pkg::*;
#(
  parameter int AVG_BASE = AVG_BASE_DEF
)(
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic                spiClk,
  input  wire logic                spiCsN,
  input  wire logic                spiSdi,
  output logic                     spiSdo,
  output logic                     spiSdoOe,
  output logic                     calInReset,
  output logic                     coreDivReset,
  output logic                     linkDivReset,
  output logic                     calValuesClear,
  output logic                     fgLinActive,
  output logic                     fgOffsetActive,
  output logic                     bgCalActive,
  output logic                     bgOffsetActive,
  output logic                     offsetRefSpare,
  output logic [DEPTH_W-1:0]       offsetAvgDepth,
  output logic [DEPTH_W-1:0]       linAvgDepth,
  output logic                     foregroundDoneFlag
);

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_CLEAR,
    ST_FG_LIN,
    ST_FG_OS,
    ST_BG,
    ST_IDLE
  } acc_state_type;

  acc_wr_type    wrReq;
  logic [14:0]   rdAddr;
  logic [7:0]    rdData;
  logic [7:0]    runCtrl_reg,  runCtrl_next;
  logic [7:0]    modeSel_reg,  modeSel_next;
  logic [7:0]    osRefSel_reg, osRefSel_next;
  logic [7:0]    avg_reg,      avg_next;
  logic          runReg;
  acc_cfg_type   cfgLive;
  acc_state_type state_reg,    state_next;
  acc_cfg_type   cfg_reg,      cfg_next;
  logic [CNT_W-1:0] cnt_reg,   cnt_next;
  logic          fgDone_reg,   fgDone_next;
  logic          fgFinish;
  acc_out_type   out_reg,      out_next;

  // Phase length in cycles, minus one, for a given averaging depth
  function automatic logic [CNT_W-1:0] avgCycles(
    input logic [DEPTH_W-1:0] depth
  );
    avgCycles = CNT_W'((AVG_BASE << depth) - 1);
  endfunction

  acc_spi_port u_spi (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .spiClk   (spiClk),
    .spiCsN   (spiCsN),
    .spiSdi   (spiSdi),
    .rdData   (rdData),
    .wrReq    (wrReq),
    .rdAddr   (rdAddr),
    .spiSdo   (spiSdo),
    .spiSdoOe (spiSdoOe)
  );

  // Register file; reserved bits are stored and read back as written
  always_comb begin
    runCtrl_next  = runCtrl_reg;
    modeSel_next  = modeSel_reg;
    osRefSel_next = osRefSel_reg;
    avg_next      = avg_reg;
    if (wrReq.valid) begin
      case (wrReq.addr)
        ADDR_RUN_CTRL:  runCtrl_next  = wrReq.data;
        ADDR_MODE_SEL:  modeSel_next  = wrReq.data;
        ADDR_OFFSET_REFERENCE_SELECT_SEL: osRefSel_next = wrReq.data;
        ADDR_AVG:       avg_next      = wrReq.data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      runCtrl_reg  <= RST_RUN_CTRL;
      modeSel_reg  <= RST_MODE_SEL;
      osRefSel_reg <= RST_OFFSET_REFERENCE_SELECT_SEL;
      avg_reg      <= RST_AVG;
    end else begin
      runCtrl_reg  <= runCtrl_next;
      modeSel_reg  <= modeSel_next;
      osRefSel_reg <= osRefSel_next;
      avg_reg      <= avg_next;
    end
  end

  // Unmapped addresses read as zero
  always_comb begin
    rdData = 8'h00;
    case (rdAddr)
      ADDR_RUN_CTRL:  rdData = runCtrl_reg;
      ADDR_MODE_SEL:  rdData = modeSel_reg;
      ADDR_OFFSET_REFERENCE_SELECT_SEL: rdData = osRefSel_reg;
      ADDR_AVG:       rdData = avg_reg;
      ADDR_STATUS:    rdData = 8'(fgDone_reg) << FGDONE_BIT;
      default:        rdData = 8'h00;
    endcase
  end

  assign runReg         = runCtrl_reg[RUN_BIT];
  assign cfgLive.bgOs   = modeSel_reg[BGOS_BIT];
  assign cfgLive.fgOs   = modeSel_reg[FGOS_BIT];
  assign cfgLive.bg     = modeSel_reg[BG_BIT];
  assign cfgLive.fg     = modeSel_reg[FG_BIT];
  assign cfgLive.offset_reference_select  = osRefSel_reg[OFFSET_REFERENCE_SELECT_BIT];
  assign cfgLive.osAvg  = avg_reg[OSAVG_LSB +: DEPTH_W];
  assign cfgLive.linAvg = avg_reg[LINAVG_LSB +: DEPTH_W];

  // Calibration sequencer
  always_comb begin
    state_next  = state_reg;
    cfg_next    = cfg_reg;
    cnt_next    = cnt_reg;
    fgDone_next = fgDone_reg;
    fgFinish    = 1'b0;
    if (!runReg) begin
      state_next  = ST_HOLD;
      fgDone_next = 1'b0;
    end else begin
      unique case (state_reg)
        ST_HOLD: begin
          // Settings written while running wait for the next start
          cfg_next   = cfgLive;
          state_next = ST_CLEAR;
        end
        ST_CLEAR: begin
          if (cfg_reg.fg) begin
            state_next = ST_FG_LIN;
            cnt_next   = avgCycles(cfg_reg.linAvg);
          end else begin
            fgFinish = 1'b1;
          end
        end
        ST_FG_LIN: begin
          if (cnt_reg != '0) begin
            cnt_next = CNT_W'(cnt_reg - 1'b1);
          end else if (cfg_reg.fgOs) begin
            state_next = ST_FG_OS;
            cnt_next   = avgCycles(cfg_reg.osAvg);
          end else begin
            fgFinish = 1'b1;
          end
        end
        ST_FG_OS: begin
          if (cnt_reg != '0) begin
            cnt_next = CNT_W'(cnt_reg - 1'b1);
          end else begin
            fgFinish = 1'b1;
          end
        end
        ST_BG: ;
        ST_IDLE: ;
      endcase
      if (fgFinish) begin
        fgDone_next = 1'b1;
        state_next  = cfg_reg.bg ? ST_BG : ST_IDLE;
      end
    end
  end

  // Outputs are derived from next state so every port is a flop
  always_comb begin
    out_next                = '0;
    out_next.calInReset     = (state_next == ST_HOLD);
    out_next.coreDivReset   = ~runCtrl_next[RUN_BIT];
    out_next.linkDivReset   = ~runCtrl_next[RUN_BIT];
    out_next.valuesClear    = (state_next == ST_CLEAR);
    out_next.fgLinActive    = (state_next == ST_FG_LIN);
    out_next.fgOffsetActive = (state_next == ST_FG_OS);
    out_next.bgActive       = (state_next == ST_BG);
    out_next.bgOffsetActive = (state_next == ST_BG) && cfg_next.bgOs;
    // Spare reference is meaningless without background enabled (mode bit 1)
    out_next.offsetRefSpare = cfg_next.offset_reference_select && cfg_next.bg;
    out_next.fgDone         = fgDone_next;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg  <= ST_HOLD;
      cfg_reg    <= '0;
      cnt_reg    <= '0;
      fgDone_reg <= 1'b0;
      out_reg    <= '0;
    end else begin
      state_reg  <= state_next;
      cfg_reg    <= cfg_next;
      cnt_reg    <= cnt_next;
      fgDone_reg <= fgDone_next;
      out_reg    <= out_next;
    end
  end

  assign calInReset         = out_reg.calInReset;
  assign coreDivReset       = out_reg.coreDivReset;
  assign linkDivReset       = out_reg.linkDivReset;
  assign calValuesClear     = out_reg.valuesClear;
  assign fgLinActive        = out_reg.fgLinActive;
  assign fgOffsetActive     = out_reg.fgOffsetActive;
  assign bgCalActive        = out_reg.bgActive;
  assign bgOffsetActive     = out_reg.bgOffsetActive;
  assign offsetRefSpare     = out_reg.offsetRefSpare;
  assign offsetAvgDepth     = cfg_reg.osAvg;
  assign linAvgDepth        = cfg_reg.linAvg;
  assign foregroundDoneFlag = out_reg.fgDone;

  // Cycles spent in the current state, read only by the checks below
  logic [CNT_W-1:0] phaseCnt_reg;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phaseCnt_reg <= '0;
    end else if (state_next != state_reg) begin
      phaseCnt_reg <= '0;
    end else begin
      phaseCnt_reg <= CNT_W'(phaseCnt_reg + 1'b1);
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence sStopped;
    !runReg ##1 !runReg;
  endsequence

  sequence sStartFg;
    state_reg == ST_CLEAR && runReg && cfg_reg.fg;
  endsequence

  sequence sStartSkip;
    state_reg == ST_CLEAR && runReg && !cfg_reg.fg;
  endsequence

  a_hold_divs_reset: assert property (
    sStopped |-> calInReset && coreDivReset && linkDivReset
                 && !foregroundDoneFlag)
    else $error("stopped calibration not held in reset");

  a_run_releases_div: assert property (
    runReg ##1 runReg |-> !coreDivReset && !linkDivReset)
    else $error("divider reset while running");

  a_cfg_sampled: assert property (
    state_reg == ST_HOLD && runReg |=> cfg_reg == $past(cfgLive)
                                       && valuesClear_q())
    else $error("settings not sampled on start");

  function automatic logic valuesClear_q();
    valuesClear_q = out_reg.valuesClear;
  endfunction

  a_fg_run_starts: assert property (
    sStartFg |=> fgLinActive && !foregroundDoneFlag)
    else $error("foreground calibration did not start");

  a_fg_skip_done: assert property (
    sStartSkip |=> foregroundDoneFlag && !fgLinActive
                   && (bgCalActive == cfg_reg.bg))
    else $error("skipped foreground did not report done");

  a_lin_length: assert property (
    state_reg == ST_FG_LIN && runReg && state_next != ST_FG_LIN
    |-> phaseCnt_reg == avgCycles(cfg_reg.linAvg))
    else $error("linearity phase length wrong");

  a_os_length: assert property (
    state_reg == ST_FG_OS && runReg && state_next != ST_FG_OS
    |-> phaseCnt_reg == avgCycles(cfg_reg.osAvg) ##1 foregroundDoneFlag)
    else $error("offset phase length wrong");

  a_fg_offset_gate: assert property (
    fgOffsetActive |-> cfg_reg.fg && cfg_reg.fgOs)
    else $error("foreground offset ran without its enables");

  a_bg_offset_gate: assert property (
    bgOffsetActive |-> bgCalActive && cfg_reg.bgOs && cfg_reg.bg)
    else $error("background offset ran without its enables");

  a_midcode_ref: assert property (
    (fgOffsetActive || bgOffsetActive) && !cfg_reg.offset_reference_select
    |-> !offsetRefSpare)
    else $error("spare reference used with mid-code selected");

endmodule

/* rtl/acc_pkg.sv */
// Shared constants and carrier types of the calibration control block
package acc_pkg;

  // Register addresses on the serial register port
  localparam logic [14:0] ADDR_RUN_CTRL  = 15'h0061;
  localparam logic [14:0] ADDR_MODE_SEL  = 15'h0062;
  localparam logic [14:0] ADDR_OFFSET_REFERENCE_SELECT_SEL = 15'h0065;
  localparam logic [14:0] ADDR_AVG       = 15'h0068;
  localparam logic [14:0] ADDR_STATUS    = 15'h006a;

  // Values after reset
  localparam logic [7:0] RST_RUN_CTRL  = 8'h01;
  localparam logic [7:0] RST_MODE_SEL  = 8'h01;
  localparam logic [7:0] RST_OFFSET_REFERENCE_SELECT_SEL = 8'h01;
  localparam logic [7:0] RST_AVG       = 8'h61;

  // Field positions
  localparam int RUN_BIT    = 0;
  localparam int BGOS_BIT   = 3;
  localparam int FGOS_BIT   = 2;
  localparam int BG_BIT     = 1;
  localparam int FG_BIT     = 0;
  localparam int OFFSET_REFERENCE_SELECT_BIT  = 2;
  localparam int OSAVG_LSB  = 4;
  localparam int LINAVG_LSB = 0;
  localparam int DEPTH_W    = 3;
  localparam int FGDONE_BIT = 0;

  // Serial frame: read flag, 15 address bits, 8 data bits, MSB first
  localparam logic [4:0] SPI_ADDR_END  = 5'h0f;
  localparam logic [4:0] SPI_DATA_FIRST = 5'h10;
  localparam logic [4:0] SPI_FRAME_END = 5'h17;

  // Averaging: a phase lasts AVG_BASE << depth cycles
  localparam int AVG_BASE_DEF = 16;
  localparam int CNT_W        = 12;

  typedef struct packed {
    logic                 bgOs;
    logic                 fgOs;
    logic                 bg;
    logic                 fg;
    logic                 offset_reference_select;
    logic [DEPTH_W-1:0]   osAvg;
    logic [DEPTH_W-1:0]   linAvg;
  } acc_cfg_type;

  typedef struct packed {
    logic        valid;
    logic [14:0] addr;
    logic [7:0]  data;
  } acc_wr_type;

  typedef struct packed {
    logic calInReset;
    logic coreDivReset;
    logic linkDivReset;
    logic valuesClear;
    logic fgLinActive;
    logic fgOffsetActive;
    logic bgActive;
    logic bgOffsetActive;
    logic offsetRefSpare;
    logic fgDone;
  } acc_out_type;

endpackage

/* rtl/acc_spi_port.sv */
// Serial register port slave: synchronised pins, frame decode, read-back
`timescale 1ns/1ps
module acc_spi_port
  import acc_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic        spiClk,
  input  wire logic        spiCsN,
  input  wire logic        spiSdi,
  input  wire logic [7:0]  rdData,
  output acc_wr_type       wrReq,
  output logic [14:0]      rdAddr,
  output logic             spiSdo,
  output logic             spiSdoOe
);

  // Pins come from another domain; stage one is read only by stage two
  logic [2:0]  syncA_reg;
  logic [2:0]  syncB_reg;
  logic        clkPrev_reg;
  logic [4:0]  bitCnt_reg,  bitCnt_next;
  logic [23:0] shift_reg,   shift_next;
  logic        rw_reg,      rw_next;
  logic [14:0] addr_reg,    addr_next;
  logic [7:0]  tx_reg,      tx_next;
  logic        sdo_reg,     sdo_next;
  logic        oe_reg,      oe_next;
  acc_wr_type  wr_reg,      wr_next;
  logic        sClk;
  logic        sCs;
  logic        sDi;
  logic        rise;
  logic        fall;

  assign sClk = syncB_reg[2];
  assign sCs  = ~syncB_reg[1];
  assign sDi  = syncB_reg[0];
  assign rise = sClk & ~clkPrev_reg;
  assign fall = ~sClk & clkPrev_reg;

  always_comb begin
    bitCnt_next = bitCnt_reg;
    shift_next  = shift_reg;
    rw_next     = rw_reg;
    addr_next   = addr_reg;
    tx_next     = tx_reg;
    sdo_next    = sdo_reg;
    wr_next     = '0;
    if (!sCs) begin
      bitCnt_next = '0;
      rw_next     = 1'b0;
    end else if (rise) begin
      shift_next  = {shift_reg[22:0], sDi};
      bitCnt_next = bitCnt_reg + 5'h01;
      if (bitCnt_reg == SPI_ADDR_END) begin
        rw_next   = shift_reg[14];
        addr_next = {shift_reg[13:0], sDi};
      end
      // A write takes effect only when the whole frame has arrived
      if (bitCnt_reg == SPI_FRAME_END && !rw_reg) begin
        wr_next.valid = 1'b1;
        wr_next.addr  = addr_reg;
        wr_next.data  = {shift_reg[6:0], sDi};
      end
    end else if (fall && rw_reg && bitCnt_reg >= SPI_DATA_FIRST) begin
      if (bitCnt_reg == SPI_DATA_FIRST) begin
        sdo_next = rdData[7];
        tx_next  = {rdData[6:0], 1'b0};
      end else begin
        sdo_next = tx_reg[7];
        tx_next  = {tx_reg[6:0], 1'b0};
      end
    end
    oe_next = sCs && rw_next && (bitCnt_next >= SPI_DATA_FIRST);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      syncA_reg   <= 3'h2;
      syncB_reg   <= 3'h2;
      clkPrev_reg <= 1'b0;
      bitCnt_reg  <= '0;
      shift_reg   <= '0;
      rw_reg      <= 1'b0;
      addr_reg    <= '0;
      tx_reg      <= '0;
      sdo_reg     <= 1'b0;
      oe_reg      <= 1'b0;
      wr_reg      <= '0;
    end else begin
      syncA_reg   <= {spiClk, spiCsN, spiSdi};
      syncB_reg   <= syncA_reg;
      clkPrev_reg <= sClk;
      bitCnt_reg  <= bitCnt_next;
      shift_reg   <= shift_next;
      rw_reg      <= rw_next;
      addr_reg    <= addr_next;
      tx_reg      <= tx_next;
      sdo_reg     <= sdo_next;
      oe_reg      <= oe_next;
      wr_reg      <= wr_next;
    end
  end

  assign wrReq    = wr_reg;
  assign rdAddr   = addr_reg;
  assign spiSdo   = sdo_reg;
  assign spiSdoOe = oe_reg;

endmodule

/* bench/acc_host_model.sv */
// Host side of the serial register port: drives whole frames bit by bit
`timescale 1ns/1ps
module acc_host_model (
  input  wire logic       clk_sys,
  output logic            spiClk,
  output logic            spiCsN,
  output logic            spiSdi,
  input  wire logic       spiSdo,
  input  wire logic       spiSdoOe,
  output logic            rdValid,
  output logic [7:0]      rdByte,
  output logic            oeSeen
);
  localparam int HALF = 6;
  initial begin
    spiClk = 1'b0;
    spiCsN = 1'b1;
    spiSdi = 1'b0;
    rdValid = 1'b0;
    rdByte = 8'h00;
    oeSeen = 1'b0;
  end
  // Idle data line keeps toggling so a stale bit never looks valid
  always @(negedge clk_sys) if (spiCsN) spiSdi <= ~spiSdi;
  task automatic xfer(input logic rd, input logic [14:0] addr,
                      input logic [7:0] wdata);
    logic [23:0] frame;
    logic [7:0]  got;
    frame = {rd, addr, wdata};
    got = 8'h00;
    oeSeen = 1'b1;
    @(negedge clk_sys);
    spiCsN = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      @(negedge clk_sys);
      spiSdi = frame[i];
      repeat (HALF) @(negedge clk_sys);
      if (i < 8) begin
        got[i] = spiSdo;
        oeSeen = oeSeen & spiSdoOe;
      end
      spiClk = 1'b1;
      repeat (HALF) @(negedge clk_sys);
      spiClk = 1'b0;
    end
    repeat (HALF) @(negedge clk_sys);
    spiCsN = 1'b1;
    if (rd) begin
      rdByte = got;
      rdValid = 1'b1;
      @(negedge clk_sys);
      rdValid = 1'b0;
    end
    repeat (HALF) @(negedge clk_sys);
  endtask
endmodule

/* bench/test_adc_calibration_control.sv */
// Self-checking bench for the calibration control block
`timescale 1ns/1ps
module test_adc_calibration_control;
  import acc_pkg::*;
  localparam int LIMIT = 40000;
  logic               clk_sys = 1'b0;
  logic               rst_n = 1'b0;
  logic               spiClk, spiCsN, spiSdi, spiSdo, spiSdoOe;
  logic               calInReset, coreDivReset, linkDivReset;
  logic               calValuesClear, fgLinActive, fgOffsetActive;
  logic               bgCalActive, bgOffsetActive, offsetRefSpare;
  logic [DEPTH_W-1:0] offsetAvgDepth, linAvgDepth;
  logic               foregroundDoneFlag, rdValid, oeSeen;
  logic [7:0]         rdByte, mode, osr, avg, lastAvg;
  logic               seenLin, seenOs, seenClear;
  logic [7:0]         expQ[$];
  int                 bad_count = 0;
  int                 samples_checked = 0;
  int                 cyc = 0;

  always #12.5 clk_sys = ~clk_sys;

  acc_cal_control #(.AVG_BASE(2)) uut (
    .clk_sys(clk_sys), .rst_n(rst_n), .spiClk(spiClk), .spiCsN(spiCsN),
    .spiSdi(spiSdi), .spiSdo(spiSdo), .spiSdoOe(spiSdoOe),
    .calInReset(calInReset), .coreDivReset(coreDivReset),
    .linkDivReset(linkDivReset), .calValuesClear(calValuesClear),
    .fgLinActive(fgLinActive), .fgOffsetActive(fgOffsetActive),
    .bgCalActive(bgCalActive), .bgOffsetActive(bgOffsetActive),
    .offsetRefSpare(offsetRefSpare), .offsetAvgDepth(offsetAvgDepth),
    .linAvgDepth(linAvgDepth), .foregroundDoneFlag(foregroundDoneFlag));

  acc_host_model host (
    .clk_sys(clk_sys), .spiClk(spiClk), .spiCsN(spiCsN), .spiSdi(spiSdi),
    .spiSdo(spiSdo), .spiSdoOe(spiSdoOe), .rdValid(rdValid),
    .rdByte(rdByte), .oeSeen(oeSeen));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checked=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Read results are matched against the oldest noted expectation
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (rdValid === 1'b1) begin
      if (expQ.size() == 0) check(rdByte, 8'hxx);
      else check(rdByte, expQ.pop_front());
    end
    if (fgLinActive === 1'b1) seenLin <= 1'b1;
    if (fgOffsetActive === 1'b1) seenOs <= 1'b1;
    if (calValuesClear === 1'b1) seenClear <= 1'b1;
    if (cyc == LIMIT) begin
      bad_count++;
      report_and_stop();
    end
  end

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    host.xfer(1'b0, a, d);
    // Output enable must be low at one or more data-phase samples of a write
    check({7'h00, oeSeen}, 8'h00);
  endtask

  task automatic rd(input logic [14:0] a, input logic [7:0] e);
    expQ.push_back(e);
    host.xfer(1'b1, a, 8'h00);
    check({7'h00, oeSeen}, 8'h01);
  endtask

  task automatic wait_done();
    for (int k = 0; k < 1000 && foregroundDoneFlag !== 1'b1; k++)
      @(negedge clk_sys);
    repeat (2) @(negedge clk_sys);
  endtask

  initial begin
    void'($urandom(84));
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    wait_done();
    check({7'h00, foregroundDoneFlag}, 8'h01);
    check({5'h00, offsetAvgDepth}, 8'h06);
    check({5'h00, linAvgDepth}, 8'h01);
    rd(ADDR_RUN_CTRL, 8'h01);
    rd(ADDR_MODE_SEL, 8'h01);
    rd(ADDR_OFFSET_REFERENCE_SELECT_SEL, 8'h01);
    rd(ADDR_AVG, 8'h61);
    rd(ADDR_STATUS, 8'h01);
    wr(ADDR_STATUS, 8'hfe);
    rd(ADDR_STATUS, 8'h01);
    rd(15'h0070, 8'h00);
    lastAvg = 8'h61;
    for (int i = 0; i < 8; i++) begin
      // Low two bits cover every foreground and background combination
      mode = {4'h0, 2'($urandom), i[1], i[0]};
      osr = {5'h00, mode[1] & 1'($urandom), 2'b01};
      avg = {1'b0, 3'($urandom), 1'b0, 3'($urandom)};
      wr(ADDR_RUN_CTRL, 8'h00);
      check({7'h00, calInReset}, 8'h01);
      check({6'h00, coreDivReset, linkDivReset}, 8'h03);
      check({7'h00, foregroundDoneFlag}, 8'h00);
      wr(ADDR_MODE_SEL, mode);
      wr(ADDR_OFFSET_REFERENCE_SELECT_SEL, osr);
      wr(ADDR_AVG, avg);
      rd(ADDR_MODE_SEL, mode);
      rd(ADDR_OFFSET_REFERENCE_SELECT_SEL, osr);
      rd(ADDR_AVG, avg);
      rd(ADDR_STATUS, 8'h00);
      check({5'h00, offsetAvgDepth}, {5'h00, lastAvg[6:4]});
      check({5'h00, linAvgDepth}, {5'h00, lastAvg[2:0]});
      seenLin = 1'b0;
      seenOs = 1'b0;
      seenClear = 1'b0;
      wr(ADDR_RUN_CTRL, 8'h01);
      wait_done();
      check({calInReset, coreDivReset, linkDivReset}, 8'h00);
      check({7'h00, seenClear}, 8'h01);
      check({7'h00, seenLin}, {7'h00, mode[0]});
      check({7'h00, seenOs}, {7'h00, mode[0] & mode[2]});
      check({7'h00, bgCalActive}, {7'h00, mode[1]});
      check({7'h00, bgOffsetActive}, {7'h00, mode[1] & mode[3]});
      check({7'h00, offsetRefSpare}, {7'h00, osr[2]});
      check({5'h00, offsetAvgDepth}, {5'h00, avg[6:4]});
      check({5'h00, linAvgDepth}, {5'h00, avg[2:0]});
      rd(ADDR_STATUS, 8'h01);
      lastAvg = avg;
    end
    // Second reset in mid-run brings the table back to its reset values
    wr(ADDR_AVG, 8'h35);
    rst_n = 1'b0;
    repeat (3) @(negedge clk_sys);
    rst_n = 1'b1;
    rd(ADDR_AVG, 8'h61);
    rd(ADDR_MODE_SEL, 8'h01);
    check({5'h00, offsetAvgDepth}, 8'h06);
    check({5'h00, linAvgDepth}, 8'h01);
    check({7'h00, foregroundDoneFlag}, 8'h01);
    report_and_stop();
  end
endmodule
